// ---- common/wcb_defines.svh ----
// Purpose: Offsets, field positions, reset values and sizes of the
//          store write-combining block.
// Assumes: Included by bare name; definitions only.
// Notes:   Sizes are fixed; the design is not parameterised.
`ifndef WCB_DEFINES_SVH
`define WCB_DEFINES_SVH

// Merge buffer and coalescing cache geometry
`define WCB_NENT       4
`define WCB_LINE_BYTES 64
`define WCB_CC_SETS    16
`define WCB_CC_WAYS    4
`define WCB_CC_LINES   64

// Register byte offsets on the bus
`define WCB_REG_CTRL   8'h00
`define WCB_REG_STATUS 8'h04
`define WCB_REG_WRCNT  8'h08

// Control fields and reset value
`define WCB_CTRL_EN    0
`define WCB_CTRL_FLUSH 1
`define WCB_CTRL_RST   32'h0000_0001

`endif

// ---- common/wcb_pkg.sv ----
// Purpose: Types shared by the write-combining block.
// Assumes: Memory type codes come from the core's type lookup.
// Notes:   Codes are written out so the core can drive them directly.
package wcb_pkg;

  // Memory type of a store or read
  typedef enum logic [2:0] {
    MT_UNCACHED    = 3'b000,
    MT_COMBINING   = 3'b001,
    MT_WRITE_THRU  = 3'b100,
    MT_WRITE_PROT  = 3'b101,
    MT_WRITE_BACK  = 3'b110
  } wcb_mtype_e;

  // Store size
  typedef enum logic [1:0] {
    SZ_BYTE  = 2'b00,
    SZ_WORD  = 2'b01,
    SZ_DWORD = 2'b10,
    SZ_QWORD = 2'b11
  } wcb_size_e;

endpackage

// ---- verilog/wcb_top.sv ----
// Purpose: Store-side write combining: a 4-entry merge buffer for
//          combining, uncached, protected, through and streaming stores,
//          and a 4-way coalescing cache for plain write-back stores.
// Assumes: Store data is lane-aligned within its quadword; stores do not
//          cross a quadword; core events are one-cycle pulses on CLK_I.
// Notes:   Registers on AHB-Lite, zero wait states, always OKAY.
// Notes on behaviour
// - Merge stores within one aligned 64-byte line
// - Byte, word, dword, qword stores fill lanes
// - Combining stores merge in any order
// - Only combining and streaming write-back stores merge in the buffer
// - Streaming buffers close on same events
// - Closing flushes the hit buffer and older
// - Port I/O closes combining
// - Serializing instructions close combining
// - Cache flush completes pending combined data
// - Close combining before a lock
// - Uncached read closes; combining read on match
// - Store hitting other-type buffer closes it
// - Close buffer once all 64 bytes valid
// - Accessed or dirty flag update closes combining
// - Store fence drains every combining buffer
// - Interrupt or exception drains pending writes
// - Full buffer goes as one 64-byte write
// - 4KB 4-way coalescing cache, write-back only
// - Four 64-byte merge buffer entries
// - Cache acts as 64 write-back merge lines
// - Flush merge buffer to keep type ordering
// - Drain in stream open order
// - Memory type governs merging
`timescale 1ns/1ps
`include "wcb_defines.svh"

module wcb_top
  import wcb_pkg::*;
(
  input  wire logic         CLK_I,
  input  wire logic         RST_I,
  // Store port from the core
  input  wire logic         ST_VALID_I,
  input  wire logic [31:0]  ST_ADDR_I,
  input  wire logic [1:0]   ST_SIZE_I,
  input  wire logic [63:0]  ST_DATA_I,
  input  wire logic [2:0]   ST_TYPE_I,
  input  wire logic         ST_NT_I,
  output logic              ST_READY_O,
  // Completion events from the core, one-cycle pulses
  input  wire logic         EV_IO_I,
  input  wire logic         EV_SERIAL_I,
  input  wire logic         EV_CFLUSH_I,
  input  wire logic         EV_LOCK_I,
  input  wire logic         EV_TLB_AD_I,
  input  wire logic         EV_FENCE_I,
  input  wire logic         EV_INTR_I,
  input  wire logic         RD_VALID_I,
  input  wire logic [31:0]  RD_ADDR_I,
  input  wire logic [2:0]   RD_TYPE_I,
  output logic              QUIET_O,
  // Line writes to the system
  output logic              SYS_VALID_O,
  output logic [31:0]       SYS_ADDR_O,
  output logic [511:0]      SYS_DATA_O,
  output logic [63:0]       SYS_BE_O,
  output logic              SYS_FULL_O,
  input  wire logic         SYS_READY_I,
  // AHB-Lite register slave
  input  wire logic         HSEL_I,
  input  wire logic [31:0]  HADDR_I,
  input  wire logic [1:0]   HTRANS_I,
  input  wire logic         HWRITE_I,
  input  wire logic [2:0]   HSIZE_I,
  input  wire logic [31:0]  HWDATA_I,
  input  wire logic         HREADY_I,
  output logic [31:0]       HRDATA_O,
  output logic              HREADYOUT_O,
  output logic              HRESP_O
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte mask of a store inside its quadword
  function automatic logic [7:0] size_mask(input logic [1:0] sz,
                                           input logic [2:0] off);
    logic [7:0] m;
    m = 8'h00;
    unique case (sz)
      SZ_BYTE:  m = 8'h01;
      SZ_WORD:  m = 8'h03;
      SZ_DWORD: m = 8'h0f;
      SZ_QWORD: m = 8'hff;
    endcase
    return m << off;
  endfunction

  // Byte enables widened to a bit mask
  function automatic logic [511:0] bit_mask(input logic [63:0] be);
    logic [511:0] m;
    m = '0;
    for (int b = 0; b < 64; b++)
      m[b*8 +: 8] = {8{be[b]}};
    return m;
  endfunction

  // Age compare on wrapping sequence numbers
  function automatic logic older(input logic [2:0] a, input logic [2:0] b);
    logic [2:0] d;
    d = a - b;
    return d[2];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  logic [3:0]         ent_v_r;
  logic [3:0]         ent_c_r;
  logic [25:0]        ent_line_r [4];
  logic [2:0]         ent_type_r [4];
  logic [2:0]         ent_seq_r  [4];
  logic [511:0]       ent_data_r [4];
  logic [63:0]        ent_be_r   [4];
  logic [2:0]         seq_r;
  logic               st_ready_r;
  logic [31:0]        ctrl_r;
  logic [31:0]        wrcnt_r;
  logic               vic_v_r;
  logic [25:0]        vic_line_r;
  logic [511:0]       vic_data_r;
  logic [63:0]        vic_be_r;
  logic [63:0]        cc_v_r;
  logic [21:0]        cc_tag_r  [64];
  logic [511:0]       cc_data_r [64];
  logic [63:0]        cc_be_r   [64];
  logic [1:0]         cc_rr_r   [16];

  ////////////////////////////////////////////////////////////////////////
  // Store decode

  logic               st_take;
  logic               st_comb;
  logic               st_to_cc;
  logic               st_to_mb;
  logic [63:0]        st_be;
  logic [511:0]       st_line;
  logic [25:0]        st_ln;
  logic [1:0]         hit_idx;
  logic               hit;
  logic               merge;
  logic               mismatch;
  logic               alloc;
  logic [1:0]         free_idx;
  logic               full_after;

  assign st_take  = ST_VALID_I && st_ready_r;
  // Type picks the path; streaming write-back behaves like combining
  assign st_comb  = ctrl_r[`WCB_CTRL_EN] &&
                    (ST_TYPE_I == MT_COMBINING ||
                     (ST_TYPE_I == MT_WRITE_BACK && ST_NT_I));
  assign st_to_cc = ST_TYPE_I == MT_WRITE_BACK && !ST_NT_I;
  assign st_to_mb = st_take && !st_to_cc;
  assign st_ln    = ST_ADDR_I[31:6];
  // Lanes of the line that this store writes
  assign st_be    = {56'h0, size_mask(ST_SIZE_I, ST_ADDR_I[2:0])}
                    << {ST_ADDR_I[5:3], 3'b000};
  assign st_line  = {8{ST_DATA_I}};

  // Open-entry hit and free slot search
  always_comb
  begin
    hit      = 1'b0;
    hit_idx  = 2'd0;
    free_idx = 2'd0;
    for (int i = 3; i >= 0; i--)
    begin
      if (ent_v_r[i] && !ent_c_r[i] && ent_line_r[i] == st_ln)
      begin
        hit     = 1'b1;
        hit_idx = 2'(i);
      end
      if (!ent_v_r[i])
        free_idx = 2'(i);
    end
  end

  // A combining store of the same line and type merges in any order, else a new entry opens
  assign merge    = st_to_mb && hit && st_comb &&
                    ent_type_r[hit_idx] == ST_TYPE_I;
  assign mismatch = st_to_mb && hit && !merge;
  assign alloc    = st_to_mb && !merge;
  assign full_after = merge && &(ent_be_r[hit_idx] | st_be);

  ////////////////////////////////////////////////////////////////////////
  // Closing

  logic               soft_flush;
  logic               ev_any;
  logic               close_all;
  logic [3:0]         trig;
  logic [3:0]         close_vec;
  logic               any_open;

  assign any_open   = |(ent_v_r & ~ent_c_r);
  // Every completion event closes all open entries, streaming ones too
  assign ev_any     = EV_IO_I || EV_SERIAL_I || EV_CFLUSH_I ||
                      EV_LOCK_I || EV_TLB_AD_I || EV_FENCE_I ||
                      EV_INTR_I || soft_flush;
  // Write-back store into the cache overtakes nothing in the buffer
  assign close_all  = ev_any || (RD_VALID_I && RD_TYPE_I == MT_UNCACHED) ||
                      (st_take && st_to_cc && any_open) ||
                      (alloc && !st_comb);

  // Matching combining read, type clash or full line close that entry
  always_comb
  begin
    for (int j = 0; j < 4; j++)
      trig[j] = ent_v_r[j] && !ent_c_r[j] &&
                ((RD_VALID_I && RD_TYPE_I == MT_COMBINING &&
                  ent_line_r[j] == RD_ADDR_I[31:6]) ||
                 (mismatch && hit_idx == 2'(j)) ||
                 (full_after && hit_idx == 2'(j)));
  end

  // A closed entry takes every older entry with it
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      close_vec[i] = close_all;
      for (int j = 0; j < 4; j++)
        if (trig[j] && !older(ent_seq_r[j], ent_seq_r[i]))
          close_vec[i] = 1'b1;
      close_vec[i] = close_vec[i] && ent_v_r[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Drain selection

  logic [1:0]         old_idx;
  logic               out_free;
  logic               vic_go;
  logic               drain;
  logic               evict;

  // Oldest valid entry by open order, not by address
  always_comb
  begin
    old_idx = 2'd0;
    for (int i = 0; i < 4; i++)
      if (ent_v_r[i] && (!ent_v_r[old_idx] ||
          older(ent_seq_r[i], ent_seq_r[old_idx])))
        old_idx = 2'(i);
  end

  assign out_free = !SYS_VALID_O || SYS_READY_I;
  assign vic_go   = out_free && vic_v_r;
  assign drain    = out_free && !vic_v_r && ent_v_r[old_idx] &&
                    ent_c_r[old_idx];

  ////////////////////////////////////////////////////////////////////////
  // Merge buffer entries

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ent_v_r <= 4'h0;
      ent_c_r <= 4'h0;
      seq_r   <= 3'd0;
      for (int i = 0; i < 4; i++)
      begin
        ent_line_r[i] <= '0;
        ent_type_r[i] <= MT_UNCACHED;
        ent_seq_r[i]  <= 3'd0;
        ent_be_r[i]   <= 64'h0;
      end
    end
    else
    begin
      ent_c_r <= ent_c_r | close_vec;
      if (drain)
        ent_v_r[old_idx] <= 1'b0;
      if (merge)
        ent_be_r[hit_idx] <= ent_be_r[hit_idx] | st_be;
      // Non-merging types open an entry that is closed at once
      if (alloc)
      begin
        ent_v_r[free_idx]    <= 1'b1;
        ent_c_r[free_idx]    <= !st_comb;
        ent_line_r[free_idx] <= st_ln;
        ent_type_r[free_idx] <= ST_TYPE_I;
        ent_seq_r[free_idx]  <= seq_r;
        ent_be_r[free_idx]   <= st_be;
        seq_r                <= seq_r + 3'd1;
      end
    end
  end

  // Entry data carries no control meaning, so it has no reset
  always_ff @(posedge CLK_I)
  begin
    if (merge)
      ent_data_r[hit_idx] <= (ent_data_r[hit_idx] & ~bit_mask(st_be)) |
                             (st_line & bit_mask(st_be));
    if (alloc)
      ent_data_r[free_idx] <= st_line & bit_mask(st_be);
  end

  ////////////////////////////////////////////////////////////////////////
  // Coalescing cache: 16 sets of 4 ways, one 64-byte line each

  logic [3:0]         cc_set;
  logic [21:0]        cc_tag;
  logic               cc_hit;
  logic [5:0]         cc_idx;
  logic [5:0]         cc_vic;

  assign cc_set = ST_ADDR_I[9:6];
  assign cc_tag = ST_ADDR_I[31:10];
  assign cc_vic = {cc_set, cc_rr_r[cc_set]};

  always_comb
  begin
    cc_hit = 1'b0;
    cc_idx = cc_vic;
    for (int w = 0; w < 4; w++)
      if (cc_v_r[{cc_set, 2'(w)}] && cc_tag_r[{cc_set, 2'(w)}] == cc_tag)
      begin
        cc_hit = 1'b1;
        cc_idx = {cc_set, 2'(w)};
      end
  end

  assign evict = st_take && st_to_cc && !cc_hit && cc_v_r[cc_vic];

  // Valid, tag, enables and round-robin victim choice
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      cc_v_r <= 64'h0;
      for (int s = 0; s < 16; s++)
        cc_rr_r[s] <= 2'd0;
      for (int l = 0; l < 64; l++)
      begin
        cc_tag_r[l] <= 22'h0;
        cc_be_r[l]  <= 64'h0;
      end
    end
    else if (st_take && st_to_cc)
    begin
      cc_v_r[cc_idx]   <= 1'b1;
      cc_tag_r[cc_idx] <= cc_tag;
      cc_be_r[cc_idx]  <= (cc_hit ? cc_be_r[cc_idx] : 64'h0) | st_be;
      if (!cc_hit)
        cc_rr_r[cc_set] <= cc_rr_r[cc_set] + 2'd1;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (st_take && st_to_cc)
      cc_data_r[cc_idx] <= ((cc_hit ? cc_data_r[cc_idx] : '0) &
                            ~bit_mask(st_be)) | (st_line & bit_mask(st_be));
  end

  // A displaced line waits here for the system port
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      vic_v_r    <= 1'b0;
      vic_line_r <= '0;
      vic_data_r <= '0;
      vic_be_r   <= 64'h0;
    end
    else if (evict)
    begin
      vic_v_r    <= 1'b1;
      vic_line_r <= {cc_tag_r[cc_vic], cc_set};
      vic_data_r <= cc_data_r[cc_vic];
      vic_be_r   <= cc_be_r[cc_vic];
    end
    else if (vic_go)
      vic_v_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // System write port

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      SYS_VALID_O <= 1'b0;
      SYS_ADDR_O  <= 32'h0;
      SYS_DATA_O  <= '0;
      SYS_BE_O    <= 64'h0;
      SYS_FULL_O  <= 1'b0;
    end
    else if (vic_go)
    begin
      SYS_VALID_O <= 1'b1;
      SYS_ADDR_O  <= {vic_line_r, 6'h00};
      SYS_DATA_O  <= vic_data_r;
      SYS_BE_O    <= vic_be_r;
      SYS_FULL_O  <= &vic_be_r;
    end
    else if (drain)
    begin
      SYS_VALID_O <= 1'b1;
      SYS_ADDR_O  <= {ent_line_r[old_idx], 6'h00};
      SYS_DATA_O  <= ent_data_r[old_idx];
      SYS_BE_O    <= ent_be_r[old_idx];
      SYS_FULL_O  <= &ent_be_r[old_idx];
    end
    else if (out_free)
      SYS_VALID_O <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Store acceptance and quiet flag

  logic [3:0]         v_nxt;
  logic               vic_nxt;

  // Next-cycle occupancy; one store needs one slot and one victim slot
  always_comb
  begin
    v_nxt = ent_v_r;
    if (drain)
      v_nxt[old_idx] = 1'b0;
    if (alloc)
      v_nxt[free_idx] = 1'b1;
  end
  assign vic_nxt = evict || (vic_v_r && !vic_go);

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      st_ready_r <= 1'b0;
    else
      st_ready_r <= !(&v_nxt) && !vic_nxt;
  end
  assign ST_READY_O = st_ready_r;

  // Nothing buffered and nothing on the port: lock or handler may start
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      QUIET_O <= 1'b1;
    else
      QUIET_O <= v_nxt == 4'h0 && !vic_nxt &&
                 !(SYS_VALID_O && !SYS_READY_I) && !drain && !vic_go;
  end

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave, zero wait states

  logic               ap_wr_r;
  logic [7:0]         ap_addr_r;
  logic               ap_take;
  logic [31:0]        rd_val;

  assign ap_take = HSEL_I && HREADY_I && HTRANS_I[1];

  always_comb
  begin
    rd_val = 32'h0;
    unique case (HADDR_I[7:0])
      `WCB_REG_CTRL:   rd_val = ctrl_r;
      `WCB_REG_STATUS: rd_val = {20'h0, ent_c_r, ent_v_r,
                                 2'b00, vic_v_r, SYS_VALID_O};
      `WCB_REG_WRCNT:  rd_val = wrcnt_r;
      default:         rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ap_wr_r     <= 1'b0;
      ap_addr_r   <= 8'h00;
      HRDATA_O    <= 32'h0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
    else
    begin
      ap_wr_r   <= ap_take && HWRITE_I;
      ap_addr_r <= HADDR_I[7:0];
      if (ap_take && !HWRITE_I)
        HRDATA_O <= |HADDR_I[31:8] ? 32'h0 : rd_val;
    end
  end

  // Control: enable bit kept, flush bit is a self-clearing pulse
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      ctrl_r <= `WCB_CTRL_RST;
    else if (ap_wr_r && ap_addr_r == `WCB_REG_CTRL)
      ctrl_r <= HWDATA_I & 32'h0000_0003;
    else
      ctrl_r[`WCB_CTRL_FLUSH] <= 1'b0;
  end
  assign soft_flush = ctrl_r[`WCB_CTRL_FLUSH];

  // System write counter; any write to it clears it, keeping a system write of that same cycle as 1
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      wrcnt_r <= 32'h0;
    else if (ap_wr_r && ap_addr_r == `WCB_REG_WRCNT)
      wrcnt_r <= {31'h0, vic_go || drain};
    else if (vic_go || drain)
      wrcnt_r <= wrcnt_r + 32'd1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  logic               prefix_ok;
  logic               full_open;
  always_comb
  begin
    prefix_ok = 1'b1;
    full_open = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      full_open = full_open || (ent_v_r[i] && !ent_c_r[i] && &ent_be_r[i]);
      for (int j = 0; j < 4; j++)
        if (ent_v_r[i] && ent_c_r[i] && ent_v_r[j] && !ent_c_r[j] &&
            older(ent_seq_r[j], ent_seq_r[i]))
          prefix_ok = 1'b0;
    end
  end

  AST_FULL_ONE_WRITE:
    assert property (SYS_VALID_O |-> SYS_FULL_O == &SYS_BE_O)
      else $error("full flag disagrees with byte enables");
  AST_PARTIAL_BE:
    assert property (SYS_VALID_O |-> SYS_BE_O != 64'h0)
      else $error("system write with no byte enabled");
  AST_EVENT_CLOSES:
    assert property (ev_any && !st_take |=> (ent_v_r & ~ent_c_r) == 4'h0)
      else $error("open entry survived a completion event");
  AST_UC_READ:
    assert property (RD_VALID_I && RD_TYPE_I == MT_UNCACHED && !st_take
                     |=> !any_open)
      else $error("uncached read left combining open");
  AST_AGE_PREFIX:
    assert property (prefix_ok)
      else $error("closed entry is younger than an open one");
  AST_NO_FULL_OPEN:
    assert property (!full_open)
      else $error("full entry still open");
  AST_TYPE_CLASH:
    assert property (mismatch |=> ent_c_r[$past(hit_idx)])
      else $error("entry of other type not closed");
  AST_WB_ORDER:
    assert property (st_take && st_to_cc |=> !any_open)
      else $error("write-back store left combining open");
  AST_HOLD_OUT:
    assert property (SYS_VALID_O && !SYS_READY_I |=>
                     SYS_VALID_O && $stable(SYS_ADDR_O) && $stable(SYS_BE_O))
      else $error("system write changed before it was taken");

endmodule

// ---- dv/wcb_sys_model.sv ----
// Purpose: System-side partner that takes line writes from the block.
// Assumes: One line per handshake on the core clock.
// Notes:   Slow mode stalls every other cycle; lines are kept in order.
`timescale 1ns/1ps
module wcb_sys_model (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         slow_i,
  input  wire logic         valid_i,
  input  wire logic [31:0]  addr_i,
  input  wire logic [63:0]  be_i,
  input  wire logic [511:0] data_i,
  input  wire logic         full_i,
  output logic              ready_o,
  output logic [15:0]       cnt_o
);
  logic [31:0] addr_q [16];
  logic [63:0] be_q   [16];
  logic        full_q [16];
  logic [511:0] data_q [16];
  //////////////////////////////////////////////////////////////////////
  // Stalling makes the writer hold its line outputs over several edges
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      ready_o <= 1'b0;
    else
      ready_o <= slow_i ? ~ready_o : 1'b1;
  // Lines are logged in arrival order so drain order can be judged
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      cnt_o <= 16'h0000;
    else if (valid_i && ready_o)
    begin
      cnt_o <= cnt_o + 16'h0001;
      addr_q[cnt_o[3:0]] <= addr_i;
      be_q[cnt_o[3:0]] <= be_i;
      full_q[cnt_o[3:0]] <= full_i;
      data_q[cnt_o[3:0]] <= data_i;
    end
endmodule

// ---- dv/wcb_top_bench.sv ----
// Purpose: Self-checking bench for the write-combining block.
// Assumes: Core events are one-cycle pulses; AHB slave has no waits.
// Notes:   Expected lines are worked out from addresses and sizes.
`timescale 1ns/1ps
`define CHK(g, e) chk((g), (e))
module wcb_top_bench import wcb_pkg::*;;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        st_v = 1'b0;
  logic        st_nt = 1'b0;
  logic        st_rdy, rd_v = 1'b0;
  logic        slow = 1'b0;
  logic        hwr = 1'b0;
  logic        hrdyo, qt, sv, sf, sys_rdy;
  logic [31:0] st_a = 32'h0, rd_a = 32'h0, ha = 32'h0, hwd = 32'h0;
  logic [31:0] hrd, sa, r;
  logic [63:0] sbe, st_d;
  logic [511:0] sd;
  logic [1:0]  st_sz = 2'b00, htr = 2'b00;
  logic [2:0]  st_t = 3'b001, rd_t = 3'b001;
  logic [6:0]  ev = 7'h00;
  logic [15:0] mc, n_seen = 16'h0000;
  int          n_mismatch = 0;
  int          n_checks = 0;
  //////////////////////////////////////////////////////////////////////
  // Each data byte names its own lane, so misplaced lanes show up
  always_comb
    for (int k = 0; k < 8; k++)
      st_d[8*k +: 8] = {st_a[7:3], 3'(k)};
  // Device and system partner
  wcb_top wcb_top_i (.CLK_I(clk), .RST_I(rst), .ST_VALID_I(st_v),
    .ST_ADDR_I(st_a), .ST_SIZE_I(st_sz), .ST_DATA_I(st_d),
    .ST_TYPE_I(st_t), .ST_NT_I(st_nt), .ST_READY_O(st_rdy),
    .EV_IO_I(ev[0]), .EV_SERIAL_I(ev[1]), .EV_CFLUSH_I(ev[2]),
    .EV_LOCK_I(ev[3]), .EV_TLB_AD_I(ev[4]), .EV_FENCE_I(ev[5]),
    .EV_INTR_I(ev[6]), .RD_VALID_I(rd_v), .RD_ADDR_I(rd_a),
    .RD_TYPE_I(rd_t), .QUIET_O(qt), .SYS_VALID_O(sv), .SYS_ADDR_O(sa),
    .SYS_DATA_O(sd), .SYS_BE_O(sbe), .SYS_FULL_O(sf),
    .SYS_READY_I(sys_rdy), .HSEL_I(1'b1), .HADDR_I(ha), .HTRANS_I(htr),
    .HWRITE_I(hwr), .HSIZE_I(3'b010), .HWDATA_I(hwd), .HREADY_I(hrdyo),
    .HRDATA_O(hrd), .HREADYOUT_O(hrdyo), .HRESP_O());
  wcb_sys_model wcb_sys_model_i (.clk_i(clk), .rst_i(rst), .slow_i(slow),
    .valid_i(sv), .addr_i(sa), .be_i(sbe), .data_i(sd), .full_i(sf),
    .ready_o(sys_rdy), .cnt_o(mc));
  //////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the span is well above the whole sequence
  always #5 clk = ~clk;
  initial
  begin
    #300us;
    n_mismatch++;
    stop_test;
  end
  //////////////////////////////////////////////////////////////////////
  // Shared drivers and comparison
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Store held until ready is seen at a falling edge, then through the next rising (taking) edge
  task automatic st(input logic [31:0] a, input logic [1:0] z,
                    input logic [2:0] t, input logic nt);
    @(posedge clk);
    {st_v, st_a, st_sz, st_t, st_nt} <= {1'b1, a, z, t, nt};
    do @(negedge clk); while (st_rdy !== 1'b1);
    @(posedge clk);
    st_v <= 1'b0;
  endtask
  // Each phase holds until hready is sampled high at a rising edge
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk);
    {htr, ha, hwr} <= {2'b10, a, w};
    do @(posedge clk); while (hrdyo !== 1'b1);
    {htr, hwd} <= {2'b00, wd};
    do @(posedge clk); while (hrdyo !== 1'b1);
    q = hrd;
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev <= 7'(1 << i);
    @(posedge clk);
    ev <= 7'h00;
  endtask
  task automatic rd(input logic [31:0] a, input logic [2:0] t);
    @(posedge clk);
    {rd_v, rd_a, rd_t} <= {1'b1, a, t};
    @(posedge clk);
    rd_v <= 1'b0;
  endtask
  // Nothing may leave while the line stays open
  task automatic hold_quiet;
    repeat (8) @(negedge clk);
    `CHK(mc, n_seen);
    `CHK(qt, 1'b0);
  endtask
  task automatic expw(input logic [31:0] a, input logic [63:0] be);
    logic [511:0] d;
    int bad;
    repeat (300) if (mc == n_seen) @(negedge clk);
    `CHK(mc > n_seen, 1'b1);
    `CHK(wcb_sys_model_i.addr_q[n_seen[3:0]], a);
    `CHK(wcb_sys_model_i.be_q[n_seen[3:0]], be);
    `CHK(wcb_sys_model_i.full_q[n_seen[3:0]], &be);
    d = wcb_sys_model_i.data_q[n_seen[3:0]];
    bad = 0;
    for (int b = 0; b < 64; b++)
      if (be[b] && d[8*b +: 8] !== (a[7:0] | 8'(b)))
        bad++;
    `CHK(bad, 0);
    n_seen++;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_merge;
    st(32'h103f, SZ_BYTE, MT_COMBINING, 1'b0);
    st(32'h1000, SZ_QWORD, MT_COMBINING, 1'b0);
    st(32'h1010, SZ_WORD, MT_COMBINING, 1'b0);
    st(32'h1024, SZ_DWORD, MT_COMBINING, 1'b0);
    hold_quiet;
    pulse(5);
    expw(32'h1000, 64'h8000_00f0_0003_00ff);
    $display("test merge done");
  endtask
  // Descending qwords under a stalling system fill and close the line
  task automatic t_full;
    slow <= 1'b1;
    for (int q = 7; q >= 0; q--)
      st(32'h2000 + 32'(8 * q), SZ_QWORD, MT_COMBINING, 1'b0);
    expw(32'h2000, 64'hffff_ffff_ffff_ffff);
    slow <= 1'b0;
    $display("test full done");
  endtask
  task automatic t_events;
    st(32'h3040, SZ_BYTE, MT_COMBINING, 1'b0);
    st(32'h3000, SZ_BYTE, MT_COMBINING, 1'b0);
    pulse(1);
    expw(32'h3040, 64'h1);
    expw(32'h3000, 64'h1);
    for (int i = 0; i < 7; i++)
    begin
      st(32'h4000 + 32'(64 * i), SZ_BYTE, MT_COMBINING, 1'b0);
      hold_quiet;
      pulse(i);
      expw(32'h4000 + 32'(64 * i), 64'h1);
    end // covered by the same loop
    $display("test events done");
  endtask
  task automatic t_types;
    st(32'h5000, SZ_BYTE, MT_UNCACHED, 1'b0);
    st(32'h5001, SZ_BYTE, MT_UNCACHED, 1'b0);
    expw(32'h5000, 64'h1);
    expw(32'h5000, 64'h2);
    st(32'h6000, SZ_BYTE, MT_WRITE_BACK, 1'b1);
    st(32'h6001, SZ_BYTE, MT_WRITE_BACK, 1'b1);
    hold_quiet;
    pulse(0);
    expw(32'h6000, 64'h3);
    st(32'h7000, SZ_BYTE, MT_COMBINING, 1'b0);
    st(32'h7001, SZ_BYTE, MT_WRITE_THRU, 1'b0);
    expw(32'h7000, 64'h1);
    expw(32'h7000, 64'h2);
    // Plain write-back stores: one set, fifth line displaces the first
    st(32'hb100, SZ_BYTE, MT_COMBINING, 1'b0);
    for (int i = 0; i < 5; i++)
      st(32'hc000 + 32'(1024 * i), SZ_BYTE, MT_WRITE_BACK, 1'b0);
    expw(32'hb100, 64'h1);
    expw(32'hc000, 64'h1);
    $display("test types done");
  endtask
  task automatic t_read;
    st(32'h8000, SZ_BYTE, MT_COMBINING, 1'b0);
    rd(32'h9000, MT_COMBINING);
    hold_quiet;
    rd(32'h8010, MT_COMBINING);
    expw(32'h8000, 64'h1);
    st(32'h8000, SZ_BYTE, MT_COMBINING, 1'b0);
    rd(32'ha000, MT_UNCACHED);
    expw(32'h8000, 64'h1);
    st(32'hd000, SZ_BYTE, MT_COMBINING, 1'b0);
    ahb(1'b1, 32'h0, 32'h3, r);
    expw(32'hd000, 64'h1);
    ahb(1'b1, 32'h0, 32'h0, r);
    st(32'he000, SZ_BYTE, MT_COMBINING, 1'b0);
    st(32'he001, SZ_BYTE, MT_COMBINING, 1'b0);
    expw(32'he000, 64'h1);
    expw(32'he000, 64'h2);
    ahb(1'b1, 32'h0, 32'h1, r);
    ahb(1'b0, 32'h0, 32'h0, r);
    `CHK(r, 32'h1);
    ahb(1'b0, 32'h8, 32'h0, r);
    `CHK(r, 32'(n_seen));
    ahb(1'b0, 32'h20, 32'h0, r);
    `CHK(r, 32'h0);
    $display("test read done");
  endtask
  //////////////////////////////////////////////////////////////////////
  // Verdict, reached from the sequence end or the hang guard
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK(qt, 1'b1);
    ahb(1'b0, 32'h0, 32'h0, r);
    `CHK(r, 32'h1);
    t_merge;
    t_full;
    t_events;
    t_types;
    t_read;
    stop_test;
  end
endmodule
